// ### inc/rpw_pkg.sv
// Shared constants and types for the read prefetch window controller
package rpw_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_W1_BASE_LO = 8'h50;
    localparam logic [7:0] OFF_W1_BASE_HI = 8'h54;
    localparam logic [7:0] OFF_W1_SIZE_POL = 8'h58;
    localparam logic [7:0] OFF_W2_BASE_LO = 8'h5c;
    localparam logic [7:0] OFF_W2_BASE_HI = 8'h60;
    localparam logic [7:0] OFF_W2_SIZE = 8'h64;
    localparam logic [7:0] OFF_PACING = 8'h68;
    localparam logic [7:0] OFF_STATUS = 8'h80;
    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_PACING = 32'hb800_0000;
    localparam int POL_BIT = 0;
    localparam int PACE_LSB = 27;
    localparam int PACE_MSB = 29;
    localparam int FRAG_LSB = 30;
    localparam int FRAG_MSB = 31;
    localparam int STAT_BUSY_BIT = 16;
    localparam int STAT_OK2_BIT = 17;
    localparam int STAT_HIT1_BIT = 18;
    localparam int STAT_HIT2_BIT = 19;
    localparam int STAT_PREF_BIT = 20;
    // ------------------------------------------------------------
    // Pacing codes and thresholds
    // ------------------------------------------------------------
    localparam logic [2:0] PACE_ALL = 3'h0;
    localparam logic [2:0] PACE_1 = 3'h1;
    localparam logic [2:0] PACE_2 = 3'h2;
    localparam logic [2:0] PACE_4 = 3'h3;
    localparam logic [3:0] TH_0 = 4'h0;
    localparam logic [3:0] TH_1 = 4'h1;
    localparam logic [3:0] TH_2 = 4'h2;
    localparam logic [3:0] TH_4 = 4'h4;
    localparam logic [3:0] TH_8 = 4'h8;
    // ------------------------------------------------------------
    // Write fragment boundaries
    // ------------------------------------------------------------
    localparam logic [1:0] FRAG_CODE_32 = 2'h0;
    localparam logic [1:0] FRAG_CODE_64 = 2'h1;
    localparam logic [7:0] FRAG_32 = 8'h20;
    localparam logic [7:0] FRAG_64 = 8'h40;
    localparam logic [7:0] FRAG_128 = 8'h80;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RPW_PC_IDLE = 2'b01,
        RPW_PC_BUSY = 2'b10
    } rpw_pace_state_t;
    typedef struct packed {
        logic valid;
        logic [63:0] addr;
    } rpw_rd_req_t;
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } rpw_wr_req_t;
    function automatic logic [3:0] pace_threshold(input logic [2:0] code);
        case (code)
            PACE_ALL: pace_threshold = TH_0;
            PACE_1: pace_threshold = TH_1;
            PACE_2: pace_threshold = TH_2;
            PACE_4: pace_threshold = TH_4;
            default: pace_threshold = TH_8;
        endcase
    endfunction
    function automatic logic [7:0] frag_bytes(input logic [1:0] code);
        case (code)
            FRAG_CODE_32: frag_bytes = FRAG_32;
            FRAG_CODE_64: frag_bytes = FRAG_64;
            default: frag_bytes = FRAG_128;
        endcase
    endfunction
endpackage

// ### hw/rpw_window_match.sv
// Address window compare: base inclusive, base plus size exclusive
`timescale 1ns/1ns
module rpw_window_match (
    // Window
    input wire logic [63:0] base,
    input wire logic [31:0] size,
    // Address under test
    input wire logic [63:0] addr,
    output logic hit
);
    logic [64:0] limit;
    always_comb begin
        limit = {1'b0, base} + {33'h0_0000_0000, size};
        hit = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < limit);
    end
endmodule

// ### hw/rpw_read_pacing.sv
// Tracks outstanding data units of the last upstream read
`timescale 1ns/1ns
module rpw_read_pacing #(
    parameter int UNIT_W = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic [2:0] pace_code,
    // Read channel events
    input wire logic rd_issue,
    input wire logic [UNIT_W-1:0] rd_units,
    input wire logic unit_rcvd,
    // Status
    output logic second_ok,
    output logic busy,
    output logic [UNIT_W-1:0] outstanding_q
);
    rpw_pkg::rpw_pace_state_t state_q;
    logic [UNIT_W-1:0] thresh;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= rpw_pkg::RPW_PC_IDLE;
            outstanding_q <= '0;
        end else begin
            case (state_q)
                rpw_pkg::RPW_PC_IDLE: begin
                    if (rd_issue && rd_units != '0) begin
                        outstanding_q <= rd_units;
                        state_q <= rpw_pkg::RPW_PC_BUSY;
                    end
                end
                rpw_pkg::RPW_PC_BUSY: begin
                    if (rd_issue) begin
                        outstanding_q <= rd_units;
                        if (rd_units == '0) begin
                            state_q <= rpw_pkg::RPW_PC_IDLE;
                        end
                    end else if (unit_rcvd) begin
                        outstanding_q <= outstanding_q - 1'b1;
                        if (outstanding_q == {{(UNIT_W-1){1'b0}}, 1'b1}) begin
                            state_q <= rpw_pkg::RPW_PC_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= rpw_pkg::RPW_PC_IDLE;
                    outstanding_q <= '0;
                end
            endcase
        end
    end

    always_comb begin
        thresh = UNIT_W'(rpw_pkg::pace_threshold(pace_code));
        busy = (state_q == rpw_pkg::RPW_PC_BUSY);
        // code zero waits for all data
        second_ok = !busy || (outstanding_q <= thresh);
    end
endmodule

// ### hw/rpw_ctrl.sv
// Prefetch window qualification, read pacing and write fragment control
// ------------------------------------------------------------
// Overview of operation
// - Window base is upper and lower words
// - Polarity bit excludes or restricts prefetch reads
// - Window 1 size from bits 31:1
// - Window 2 size is full 32 bits
// - Window check gates only enabled prefetch mode
// - Code 000 waits for all completions
// - Codes hold until 1,2,4,8 units remain
// - Write fragments at 32, 64, 128 bytes
// ------------------------------------------------------------
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module rpw_ctrl #(
    parameter int UNIT_W = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic [rpw_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rpw_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rpw_pkg::DATA_W-1:0] reg_rdata,
    // Prefetch mode field held elsewhere
    input wire logic [3:0] prefetch_mode,
    // PCI memory read qualification
    input wire rpw_pkg::rpw_rd_req_t rd_req,
    output logic prefetch_ok_valid,
    output logic prefetch_ok,
    // Upstream read pacing
    input wire logic rd_issue,
    input wire logic [UNIT_W-1:0] rd_units,
    input wire logic read_data_unit,
    output logic second_rd_ok,
    // Upstream write fragmentation
    input wire rpw_pkg::rpw_wr_req_t wr_req,
    output logic frag_valid,
    output logic [7:0] frag_len,
    output logic [7:0] frag_boundary
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] w1_base_lo_q;
    logic [31:0] w1_base_hi_q;
    logic [31:0] w1_size_pol_q;
    logic [31:0] w2_base_lo_q;
    logic [31:0] w2_base_hi_q;
    logic [31:0] w2_size_q;
    logic [2:0] pace_code_q;
    logic [1:0] frag_code_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // Window 1 base and size
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            w1_base_lo_q <= rpw_pkg::RST_ZERO;
            w1_base_hi_q <= rpw_pkg::RST_ZERO;
            w1_size_pol_q <= rpw_pkg::RST_ZERO;
        end else if (reg_wr) begin
            if (reg_addr == rpw_pkg::OFF_W1_BASE_LO) begin
                w1_base_lo_q <= reg_wdata;
            end
            if (reg_addr == rpw_pkg::OFF_W1_BASE_HI) begin
                w1_base_hi_q <= reg_wdata;
            end
            if (reg_addr == rpw_pkg::OFF_W1_SIZE_POL) begin
                w1_size_pol_q <= reg_wdata;
            end
        end
    end

    // Window 2 base and size
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            w2_base_lo_q <= rpw_pkg::RST_ZERO;
            w2_base_hi_q <= rpw_pkg::RST_ZERO;
            w2_size_q <= rpw_pkg::RST_ZERO;
        end else if (reg_wr) begin
            if (reg_addr == rpw_pkg::OFF_W2_BASE_LO) begin
                w2_base_lo_q <= reg_wdata;
            end
            if (reg_addr == rpw_pkg::OFF_W2_BASE_HI) begin
                w2_base_hi_q <= reg_wdata;
            end
            if (reg_addr == rpw_pkg::OFF_W2_SIZE) begin
                w2_size_q <= reg_wdata;
            end
        end
    end

    // Pacing and fragment fields; low bits are reserved
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pace_code_q <= rpw_pkg::RST_PACING[rpw_pkg::PACE_MSB:rpw_pkg::PACE_LSB];
            frag_code_q <= rpw_pkg::RST_PACING[rpw_pkg::FRAG_MSB:rpw_pkg::FRAG_LSB];
        end else if (reg_wr && reg_addr == rpw_pkg::OFF_PACING) begin
            pace_code_q <= reg_wdata[rpw_pkg::PACE_MSB:rpw_pkg::PACE_LSB];
            frag_code_q <= reg_wdata[rpw_pkg::FRAG_MSB:rpw_pkg::FRAG_LSB];
        end
    end

    // ------------------------------------------------------------
    // Window compare
    // ------------------------------------------------------------
    logic [63:0] w1_base;
    logic [63:0] w2_base;
    logic [31:0] w1_size;
    logic w1_hit;
    logic w2_hit;
    logic pol;

    always_comb begin
        w1_base = {w1_base_hi_q, w1_base_lo_q};
        w2_base = {w2_base_hi_q, w2_base_lo_q};
        w1_size = {w1_size_pol_q[31:1], 1'b0};
        pol = w1_size_pol_q[rpw_pkg::POL_BIT];
    end

    rpw_window_match u_win1 (
        .base(w1_base),
        .size(w1_size),
        .addr(rd_req.addr),
        .hit(w1_hit)
    );

    rpw_window_match u_win2 (
        .base(w2_base),
        .size(w2_size_q),
        .addr(rd_req.addr),
        .hit(w2_hit)
    );

    // ------------------------------------------------------------
    // Prefetch qualification
    // ------------------------------------------------------------
    logic in_any;
    logic qual_d;
    logic ok_q;
    logic ok_valid_q;
    logic w1_hit_q;
    logic w2_hit_q;

    always_comb begin
        in_any = w1_hit || w2_hit;
        // only applies while prefetch mode enabled
        qual_d = (prefetch_mode != 4'h0) && (pol ? in_any : !in_any);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ok_q <= 1'b0;
            ok_valid_q <= 1'b0;
        end else begin
            ok_valid_q <= rd_req.valid;
            if (rd_req.valid) begin
                ok_q <= qual_d;
            end
        end
    end

    // Last hit bits kept for status
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            w1_hit_q <= 1'b0;
            w2_hit_q <= 1'b0;
        end else if (rd_req.valid) begin
            w1_hit_q <= w1_hit;
            w2_hit_q <= w2_hit;
        end
    end

    assign prefetch_ok = ok_q;
    assign prefetch_ok_valid = ok_valid_q;

    // ------------------------------------------------------------
    // Read pacing
    // ------------------------------------------------------------
    logic pace_busy;
    logic [UNIT_W-1:0] outstanding;

    rpw_read_pacing #(
        .UNIT_W(UNIT_W)
    ) u_pacing (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pace_code(pace_code_q),
        .rd_issue(rd_issue),
        .rd_units(rd_units),
        .unit_rcvd(read_data_unit),
        .second_ok(second_rd_ok),
        .busy(pace_busy),
        .outstanding_q(outstanding)
    );

    // ------------------------------------------------------------
    // Write fragmentation
    // ------------------------------------------------------------
    logic [7:0] bound;
    logic [7:0] offs;
    logic [7:0] frag_len_q;
    logic [7:0] bound_q;
    logic frag_valid_q;

    always_comb begin
        bound = rpw_pkg::frag_bytes(frag_code_q);
        offs = {1'b0, wr_req.addr} & (bound - 8'h01);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            frag_len_q <= rpw_pkg::FRAG_128;
            bound_q <= rpw_pkg::FRAG_128;
            frag_valid_q <= 1'b0;
        end else begin
            frag_valid_q <= wr_req.valid;
            bound_q <= bound;
            if (wr_req.valid) begin
                frag_len_q <= bound - offs;
            end
        end
    end

    assign frag_len = frag_len_q;
    assign frag_boundary = bound_q;
    assign frag_valid = frag_valid_q;

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rpw_pkg::RST_ZERO;
        case (reg_addr)
            rpw_pkg::OFF_W1_BASE_LO: rdata_d = w1_base_lo_q;
            rpw_pkg::OFF_W1_BASE_HI: rdata_d = w1_base_hi_q;
            rpw_pkg::OFF_W1_SIZE_POL: rdata_d = w1_size_pol_q;
            rpw_pkg::OFF_W2_BASE_LO: rdata_d = w2_base_lo_q;
            rpw_pkg::OFF_W2_BASE_HI: rdata_d = w2_base_hi_q;
            rpw_pkg::OFF_W2_SIZE: rdata_d = w2_size_q;
            rpw_pkg::OFF_PACING: begin
                rdata_d[rpw_pkg::PACE_MSB:rpw_pkg::PACE_LSB] = pace_code_q;
                rdata_d[rpw_pkg::FRAG_MSB:rpw_pkg::FRAG_LSB] = frag_code_q;
            end
            rpw_pkg::OFF_STATUS: begin
                rdata_d[UNIT_W-1:0] = outstanding;
                rdata_d[rpw_pkg::STAT_BUSY_BIT] = pace_busy;
                rdata_d[rpw_pkg::STAT_OK2_BIT] = second_rd_ok;
                rdata_d[rpw_pkg::STAT_HIT1_BIT] = w1_hit_q;
                rdata_d[rpw_pkg::STAT_HIT2_BIT] = w2_hit_q;
                rdata_d[rpw_pkg::STAT_PREF_BIT] = ok_q;
            end
            default: rdata_d = rpw_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_q <= rpw_pkg::RST_ZERO;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= rpw_pkg::RST_ZERO;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    base_hi_write_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        reg_wr && reg_addr == rpw_pkg::OFF_W1_BASE_HI
        |=> w1_base[63:32] == $past(reg_wdata))
        else $error("window 1 upper base not taken");

    polarity_exclude_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_req.valid && !pol && w1_hit |=> prefetch_ok_valid && !prefetch_ok)
        else $error("read inside excluded window allowed prefetch");

    polarity_only_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_req.valid && pol && !w1_hit && !w2_hit |=> !prefetch_ok)
        else $error("read outside restricted window allowed prefetch");

    w1_size_lsb_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        reg_wr && reg_addr == rpw_pkg::OFF_W1_SIZE_POL
        |=> w1_size == {$past(reg_wdata[31:1]), 1'b0})
        else $error("window 1 size not taken from bits 31:1");

    w2_size_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        reg_wr && reg_addr == rpw_pkg::OFF_W2_SIZE |=> w2_size_q == $past(reg_wdata))
        else $error("window 2 size not stored");

    mode_gate_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_req.valid && prefetch_mode == 4'h0 |=> !prefetch_ok)
        else $error("prefetch allowed while mode disabled");

    pace_all_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        pace_code_q == rpw_pkg::PACE_ALL && outstanding != '0 && pace_busy
        |-> !second_rd_ok)
        else $error("second read allowed with data pending");

    pace_eight_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        pace_code_q[2] && pace_busy |-> second_rd_ok == (outstanding <= UNIT_W'(8)))
        else $error("pacing threshold of eight wrong");

    frag_len_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_req.valid && frag_code_q == rpw_pkg::FRAG_CODE_32
        |=> frag_valid && frag_len == 8'h20 - {3'h0, $past(wr_req.addr[4:0])})
        else $error("32-byte fragment length wrong");

    inside_base_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_req.valid && w2_size_q != 32'h0000_0000 && rd_req.addr == w2_base |-> w2_hit)
        else $error("window base address not inside window");

    read_latency_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        reg_rd && reg_addr == rpw_pkg::OFF_W2_SIZE |=> reg_rdata == w2_size_q)
        else $error("register read data late or wrong");

    polarity_allow_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_req.valid && pol && w1_hit && prefetch_mode != 4'h0 |=> prefetch_ok)
        else $error("read inside restricted window refused prefetch");

    frag_wide_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_req.valid && frag_code_q[1]
        |=> frag_valid && frag_len == rpw_pkg::FRAG_128 - {1'b0, $past(wr_req.addr)})
        else $error("128-byte fragment length wrong");
endmodule

// ### testbench/rpw_link_partner.sv
// Upstream link partner model: returns data units for the latest read
`timescale 1ns/1ns
module rpw_link_partner #(
    parameter int UNIT_W = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Read requests sent upstream
    input wire logic rd_issue,
    input wire logic [UNIT_W-1:0] rd_units,
    input wire logic slow,
    // Completion data units
    output logic read_data_unit
);
    logic [UNIT_W-1:0] pend_q;
    logic [1:0] gap_q;

    // ------------------------------------------------------------
    // Completion return
    // ------------------------------------------------------------
    // A new request replaces the old one; slow mode spaces units three cycles apart
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pend_q <= '0;
            gap_q <= 2'h0;
            read_data_unit <= 1'b0;
        end else if (rd_issue) begin
            pend_q <= rd_units;
            gap_q <= 2'h0;
            read_data_unit <= 1'b0;
        end else begin
            gap_q <= (gap_q == 2'h2 || !slow) ? 2'h0 : gap_q + 2'h1;
            read_data_unit <= pend_q != '0 && gap_q == 2'h0;
            if (pend_q != '0 && gap_q == 2'h0) begin
                pend_q <= pend_q - 1'b1;
            end
        end
    end
endmodule

// ### testbench/rpw_ctrl_tb.sv
// Self-checking bench for the read prefetch window controller
`timescale 1ns/1ns
module rpw_ctrl_tb;
    localparam int UW = 10;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] prefetch_mode = 4'h0;
    rpw_pkg::rpw_rd_req_t rd_req = '0;
    rpw_pkg::rpw_wr_req_t wr_req = '0;
    logic prefetch_ok_valid, prefetch_ok, read_data_unit, second_rd_ok, frag_valid;
    logic rd_issue = 1'b0;
    logic slow = 1'b0;
    logic [UW-1:0] rd_units = '0;
    logic [7:0] frag_len, frag_boundary;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h0001_2cce;
    logic [31:0] qr[$];
    logic [31:0] qp[$];
    logic [15:0] qf[$];
    logic rd_seen_q = 1'b0;
    logic [UW-1:0] cnt_q = '0;
    logic [3:0] th = 4'h0;
    logic pace_chk = 1'b0;
    logic [7:0] offs[7] = '{8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68};

    always #50 sys_clk = ~sys_clk;

    rpw_ctrl #(.UNIT_W(UW)) u_rpw_ctrl (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .prefetch_mode(prefetch_mode), .rd_req(rd_req),
        .prefetch_ok_valid(prefetch_ok_valid), .prefetch_ok(prefetch_ok),
        .rd_issue(rd_issue), .rd_units(rd_units), .read_data_unit(read_data_unit),
        .second_rd_ok(second_rd_ok), .wr_req(wr_req), .frag_valid(frag_valid),
        .frag_len(frag_len), .frag_boundary(frag_boundary));

    rpw_link_partner #(.UNIT_W(UW)) u_rpw_link_partner (
        .sys_clk(sys_clk), .resetn(resetn), .rd_issue(rd_issue), .rd_units(rd_units),
        .slow(slow), .read_data_unit(read_data_unit));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic inw(input logic [63:0] a, b, input logic [31:0] s);
        return a >= b && {1'b0, a} < {1'b0, b} + {33'h0, s};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        qr.push_back(e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic qual(input logic [63:0] a, input logic e);
        qp.push_back({31'h0, e});
        @(posedge sys_clk);
        rd_req <= '{valid: 1'b1, addr: a};
        @(posedge sys_clk);
        rd_req.valid <= 1'b0;
    endtask

    task automatic frag(input logic [6:0] a, input logic [7:0] b);
        qf.push_back({b, 8'(b - a % b)});
        @(posedge sys_clk);
        wr_req <= '{valid: 1'b1, addr: a};
        @(posedge sys_clk);
        wr_req.valid <= 1'b0;
    endtask

    task automatic issue(input logic [UW-1:0] n);
        @(posedge sys_clk);
        rd_issue <= 1'b1;
        rd_units <= n;
        @(posedge sys_clk);
        rd_issue <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(posedge sys_clk) rd_seen_q <= reg_rd;

    // Outstanding units of the latest read, as the far side returns them
    always @(posedge sys_clk) begin
        if (!resetn || rd_issue) cnt_q <= resetn ? rd_units : '0;
        else if (read_data_unit && cnt_q != '0) cnt_q <= cnt_q - 1'b1;
    end

    always @(negedge sys_clk) begin
        if (rd_seen_q) chk(reg_rdata, qr.pop_front(), "register read");
        if (prefetch_ok_valid) chk(prefetch_ok, qp.pop_front(), "prefetch verdict");
        if (frag_valid) chk({frag_boundary, frag_len}, qf.pop_front(), "fragment");
        if (pace_chk) chk(second_rd_ok, cnt_q <= th, "second read gate");
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0] b1, b2, a;
        logic [31:0] s1, s2, sz;
        logic pol, hit;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk({second_rd_ok, frag_len, frag_boundary}, {1'b1, 8'h80, 8'h80}, "reset");
        for (int i = 0; i < 7; i++) rreg(offs[i], i == 6 ? 32'hb800_0000 : 32'h0);
        for (int i = 0; i < 7; i++) begin
            sz = xs();
            wreg(offs[i], sz);
            rreg(offs[i], i == 6 ? sz & 32'hf800_0000 : sz);
        end
        wreg(8'h4c, xs());
        rreg(8'h4c, 32'h0);
        // Window edges, both polarities, window 2 empty in half the passes
        for (int k = 0; k < 4; k++) begin
            pol = k[0];
            b1 = {xs() >> 1, xs()};
            b2 = {xs() >> 1, xs()};
            s1 = xs() & 32'hffff_fffe;
            s2 = k[1] ? 32'h0 : xs();
            wreg(8'h50, b1[31:0]);
            wreg(8'h54, b1[63:32]);
            wreg(8'h58, {s1[31:1], pol});
            wreg(8'h5c, b2[31:0]);
            wreg(8'h60, b2[63:32]);
            wreg(8'h64, s2);
            prefetch_mode <= 4'(xs()) | 4'h1;
            for (int j = 0; j < 9; j++) begin
                sz = j < 4 ? s1 : s2;
                a = (j < 4 ? b1 : b2) + {32'h0, j % 4 > 1 ? sz : 32'h0} - 64'(j % 2 == 0);
                if (j == 8) a = {xs(), xs()};
                hit = inw(a, b1, s1) || inw(a, b2, s2);
                qual(a, pol ? hit : !hit);
            end
        end
        prefetch_mode <= 4'h0;
        qual(b1, 1'b0);
        rreg(8'h80, {11'h0, 1'b0, inw(b1, b2, s2), inw(b1, b1, s1), 1'b1, 17'h0});
        // Every pacing code, prompt and slow completions, request replaced midway
        for (int c = 0; c < 8; c++) begin
            wreg(8'h68, {2'h2, 3'(c), 27'h0});
            th = c == 0 ? 4'h0 : c == 1 ? 4'h1 : c == 2 ? 4'h2 : c == 3 ? 4'h4 : 4'h8;
            slow <= c[0];
            pace_chk <= 1'b1;
            issue(UW'(12 + c));
            repeat (6) @(posedge sys_clk);
            issue(UW'(9));
            repeat (40) @(posedge sys_clk);
            pace_chk <= 1'b0;
        end
        // Every fragment code, fixed unaligned start 05 then three random starts
        for (int c = 0; c < 4; c++) begin
            wreg(8'h68, {2'(c), 30'h0});
            repeat (2) @(posedge sys_clk);
            for (int j = 0; j < 4; j++) begin
                frag(j == 0 ? 7'h05 : 7'(xs()), c[1] ? 8'h80 : c[0] ? 8'h40 : 8'h20);
            end
        end
        repeat (4) @(posedge sys_clk);
        report_and_stop();
    end

    initial begin
        #(5000 * 100);
        failures++;
        report_and_stop();
    end
endmodule
